// file: pin_routing_pkg.sv
// shared constants for the peripheral pin routing block
package pin_routing_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, one word per register)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOCK = 8'h00;
    localparam logic [7:0] ADDR_IN_BASE = 8'h40;
    localparam logic [7:0] ADDR_OUT_BASE = 8'hC0;
    localparam int SEL_W = 5;
    localparam int LOCK_BIT = 0;
    // ------------------------------------------------------------
    // keys and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [4:0] OUT_SEL_RESET = 5'h00;
    localparam logic [4:0] IN_SEL_RESET = 5'h00;
    // ------------------------------------------------------------
    // input codes
    // ------------------------------------------------------------
    localparam logic [4:0] IN_PORT_A_BASE = 5'h00;
    localparam logic [4:0] IN_PORT_C_BASE = 5'h10;
    localparam int PINS_PER_PORT = 6;
    // ------------------------------------------------------------
    // output source codes
    // ------------------------------------------------------------
    localparam logic [4:0] SRC_LATCH = 5'h00;
    localparam logic [4:0] SRC_PULSE_WIDTH_FIVE = 5'h02;
    localparam logic [4:0] SRC_PULSE_WIDTH_SIX = 5'h03;
    localparam logic [4:0] SRC_CELL1 = 5'h04;
    localparam logic [4:0] SRC_CELL2 = 5'h05;
    localparam logic [4:0] SRC_WAVE_A = 5'h08;
    localparam logic [4:0] SRC_WAVE_B = 5'h09;
    localparam logic [4:0] SRC_WAVE_C = 5'h0A;
    localparam logic [4:0] SRC_WAVE_D = 5'h0B;
    localparam logic [4:0] SRC_CAPTURE_COMPARE_ONE = 5'h0C;
    localparam logic [4:0] SRC_CAPTURE_COMPARE_TWO = 5'h0D;
    localparam logic [4:0] SRC_ASYNC_TX = 5'h14;
    localparam logic [4:0] SRC_SYNC_DATA = 5'h15;
    localparam logic [4:0] SRC_CMP1 = 5'h16;
    localparam logic [4:0] SRC_CMP2 = 5'h17;
    localparam logic [4:0] SRC_SER_CLK = 5'h18;
    localparam logic [4:0] SRC_SER_DATA = 5'h19;
    localparam logic [4:0] SRC_TIMER0 = 5'h1C;
    localparam logic [4:0] SRC_NCO = 5'h1D;
    localparam logic [4:0] SRC_REFCLK = 5'h1E;
    localparam logic [4:0] SRC_MOD = 5'h1F;
    // index of each source in the peripheral output vector
    localparam int PO_PULSE_WIDTH_FIVE = 0;
    localparam int PO_PULSE_WIDTH_SIX = 1;
    localparam int PO_CELL1 = 2;
    localparam int PO_CELL2 = 3;
    localparam int PO_WAVE = 4;
    localparam int PO_CAPTURE_COMPARE_ONE = 8;
    localparam int PO_CAPTURE_COMPARE_TWO = 9;
    localparam int PO_ASYNC_TX = 10;
    localparam int PO_SYNC_DATA = 11;
    localparam int PO_CMP1 = 12;
    localparam int PO_CMP2 = 13;
    localparam int PO_SER_CLK = 14;
    localparam int PO_SER_DATA = 15;
    localparam int PO_TIMER0 = 16;
    localparam int PO_NCO = 17;
    localparam int PO_REFCLK = 18;
    localparam int PO_MOD = 19;
    localparam int PO_COUNT = 20;
endpackage

// file: routing_lock_fsm.sv
// lock bit with key sequence and one-shot mode
`timescale 1ns/1ps
module routing_lock_fsm
    import pin_routing_pkg::*;
(
    input wire logic clk,
    input wire logic por_n,
    input wire logic one_shot_lock_config,
    input wire logic lock_wr,
    input wire logic [7:0] lock_wdata,
    output logic routing_locked
);
    // ------------------------------------------------------------
    // key sequence states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_GOT1 = 3'b010,
        KEY_OPEN = 3'b100
    } key_state_t;

    key_state_t state_reg, state_next;
    logic locked_reg, locked_next;
    logic used_reg, used_next;
    logic may_change;

    // one-shot mode allows a single change per reset
    assign may_change = !(one_shot_lock_config && used_reg);

    // next state: keys must come back to back
    always_comb begin
        state_next = state_reg;
        locked_next = locked_reg;
        used_next = used_reg;
        if (lock_wr) begin
            case (state_reg)
                KEY_IDLE: state_next = (lock_wdata == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
                KEY_GOT1: state_next = (lock_wdata == KEY_SECOND) ? KEY_OPEN :
                    ((lock_wdata == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE);
                KEY_OPEN: begin
                    state_next = KEY_IDLE;
                    if (may_change && (lock_wdata[LOCK_BIT] != locked_reg)) begin
                        locked_next = lock_wdata[LOCK_BIT];
                        if (lock_wdata[LOCK_BIT]) begin
                            used_next = 1'b1;
                        end
                    end
                end
                default: state_next = KEY_IDLE;
            endcase
        end
    end

    // state registers, cleared only by power-on reset
    always_ff @(posedge clk) begin
        if (!por_n) begin
            state_reg <= KEY_IDLE;
            locked_reg <= 1'b0;
            used_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            locked_reg <= locked_next;
            used_reg <= used_next;
        end
    end

    assign routing_locked = locked_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LOCK_NEEDS_KEYS: assert property (@(posedge clk) disable iff (!por_n)
        $past(por_n) && $changed(locked_reg) |-> $past(state_reg) == KEY_OPEN && $past(lock_wr))
        else $error("lock bit changed without key sequence");
    AST_ONE_SHOT: assert property (@(posedge clk) disable iff (!por_n)
        (one_shot_lock_config && used_reg && $past(used_reg)) |-> $stable(locked_reg))
        else $error("lock bit changed twice in one-shot mode");
    AST_BAD_KEY: assert property (@(posedge clk) disable iff (!por_n)
        (state_reg == KEY_GOT1 && lock_wr && lock_wdata != KEY_SECOND) |=> state_reg != KEY_OPEN)
        else $error("sequence opened after wrong second key");
    COV_UNLOCK: cover property (@(posedge clk) disable iff (!por_n)
        locked_reg ##1 !locked_reg);
    COV_LOCK: cover property (@(posedge clk) disable iff (!por_n)
        !locked_reg ##1 locked_reg);
endmodule

// file: pin_output_mux.sv
// one pin: output source select and driver enable
`timescale 1ns/1ps
module pin_output_mux
    import pin_routing_pkg::*;
(
    input wire logic [4:0] sel,
    input wire logic latch_bit,
    input wire logic dir_input,
    input wire logic [PO_COUNT-1:0] periph_out,
    input wire logic [PO_COUNT-1:0] periph_oe_n,
    output logic pin_out,
    output logic pin_oe_n
);
    logic src_val;
    logic src_owns;

    // source decode; reserved codes give low
    always_comb begin
        src_val = 1'b0;
        src_owns = 1'b0;
        case (sel)
            SRC_LATCH: src_val = latch_bit;
            SRC_PULSE_WIDTH_FIVE: src_val = periph_out[PO_PULSE_WIDTH_FIVE];
            SRC_PULSE_WIDTH_SIX: src_val = periph_out[PO_PULSE_WIDTH_SIX];
            SRC_CELL1: src_val = periph_out[PO_CELL1];
            SRC_CELL2: src_val = periph_out[PO_CELL2];
            SRC_WAVE_A, SRC_WAVE_B, SRC_WAVE_C, SRC_WAVE_D: begin
                src_val = periph_out[PO_WAVE + int'(sel[1:0])];
                src_owns = 1'b1;
            end
            SRC_CAPTURE_COMPARE_ONE: src_val = periph_out[PO_CAPTURE_COMPARE_ONE];
            SRC_CAPTURE_COMPARE_TWO: src_val = periph_out[PO_CAPTURE_COMPARE_TWO];
            SRC_ASYNC_TX: src_val = periph_out[PO_ASYNC_TX];
            SRC_SYNC_DATA: begin
                src_val = periph_out[PO_SYNC_DATA];
                src_owns = 1'b1;
            end
            SRC_CMP1: src_val = periph_out[PO_CMP1];
            SRC_CMP2: src_val = periph_out[PO_CMP2];
            SRC_SER_CLK: begin
                src_val = periph_out[PO_SER_CLK];
                src_owns = 1'b1;
            end
            SRC_SER_DATA: begin
                src_val = periph_out[PO_SER_DATA];
                src_owns = 1'b1;
            end
            SRC_TIMER0: src_val = periph_out[PO_TIMER0];
            SRC_NCO: src_val = periph_out[PO_NCO];
            SRC_REFCLK: src_val = periph_out[PO_REFCLK];
            SRC_MOD: src_val = periph_out[PO_MOD];
            default: src_val = 1'b0;
        endcase
    end

    // direction control rules unless the peripheral owns the driver
    assign pin_out = src_val;
    assign pin_oe_n = src_owns ? periph_oe_n[(sel == SRC_SER_CLK) ? PO_SER_CLK :
        (sel == SRC_SER_DATA) ? PO_SER_DATA : (sel == SRC_SYNC_DATA) ? PO_SYNC_DATA :
        PO_WAVE + int'(sel[1:0])] : dir_input;
endmodule

// file: peripheral_pin_routing_lock.sv
// peripheral pin routing matrix with lock, behind a Wishbone slave
// What this block does
// - only digital signals pass the selectors
// - each peripheral input has 5-bit selector
// - codes pick port A or C pins
// - each pin has 5-bit source selector
// - code zero drives pin from latch
// - low output codes map PWM, cells, waveform, CCP
// - high output codes map serial, comparators, timers
// - direction control normally enables the driver
// - serial sources other than async tx, and waveform sources, override direction
// - locked bit blocks all selector writes
// - lock change needs 0x55 then 0xAA
// - one-shot mode allows one change per reset
// - otherwise lock may change many times
// - selectors always readable
// - sleep leaves selections alone
// - power-on reset restores defaults, clears lock
// - other resets keep the selections
// - lock flag at bit zero, rest zero
`timescale 1ns/1ps
module peripheral_pin_routing_lock
    import pin_routing_pkg::*;
#(
    parameter int N_INPUTS = 19,
    parameter int N_PINS = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic one_shot_lock_config,
    input wire logic sleep_active,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic [N_PINS-1:0] pin_in,
    input wire logic [N_PINS-1:0] port_output_latch_bit,
    input wire logic [N_PINS-1:0] pin_direction_control,
    input wire logic [PO_COUNT-1:0] periph_out,
    input wire logic [PO_COUNT-1:0] periph_oe_n,
    output logic [N_INPUTS-1:0] periph_in,
    output logic [N_PINS-1:0] pin_out,
    output logic [N_PINS-1:0] pin_oe_n,
    output logic routing_locked
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    initial begin
        if (N_PINS != 2 * PINS_PER_PORT || N_INPUTS < 1 ||
            N_INPUTS > int'(ADDR_OUT_BASE - ADDR_IN_BASE) / 4) begin
            $error("unsupported pin or input count");
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr_go;
    logic hit_lock;
    logic hit_in;
    logic hit_out;
    logic in_rgn;
    logic [5:0] word_idx;
    logic mapped;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // word index within a region
    function automatic logic [5:0] region_index(input logic [7:0] adr, input logic [7:0] base);
        logic [7:0] off;
        off = adr - base;
        return off[7:2];
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    // input selectors span the two middle quarters, so more than sixteen fit
    assign in_rgn = wb_adr_i >= ADDR_IN_BASE && wb_adr_i < ADDR_OUT_BASE;
    assign word_idx = in_rgn ? region_index(wb_adr_i, ADDR_IN_BASE) :
        region_index(wb_adr_i, ADDR_OUT_BASE);
    assign hit_lock = wb_adr_i == ADDR_LOCK;
    assign hit_in = in_rgn && wb_adr_i[1:0] == 2'b00 && int'(word_idx) < N_INPUTS;
    assign hit_out = wb_adr_i >= ADDR_OUT_BASE && wb_adr_i[1:0] == 2'b00 &&
        int'(word_idx) < N_PINS;
    assign mapped = hit_lock || hit_in || hit_out;
    assign wr_go = req && mapped && wb_we_i && wb_sel_i[0];

    // ------------------------------------------------------------
    // lock control
    // ------------------------------------------------------------
    logic lock_wr;
    assign lock_wr = wr_go && hit_lock;

    routing_lock_fsm u_lock (
        .clk(clk),
        .por_n(por_n),
        .one_shot_lock_config(one_shot_lock_config),
        .lock_wr(lock_wr),
        .lock_wdata(wb_dat_i[7:0]),
        .routing_locked(routing_locked)
    );

    // ------------------------------------------------------------
    // selector registers, power-on reset only; sleep has no effect
    // ------------------------------------------------------------
    logic [4:0] in_sel_reg [N_INPUTS];
    logic [4:0] out_sel_reg [N_PINS];
    logic sel_wr_ok;
    assign sel_wr_ok = wr_go && !routing_locked;

    genvar gi;
    generate
        for (gi = 0; gi < N_INPUTS; gi++) begin : g_in
            // input selector and its pin decode
            always_ff @(posedge clk) begin
                if (!por_n) begin
                    in_sel_reg[gi] <= IN_SEL_RESET;
                end else if (sel_wr_ok && hit_in && int'(word_idx) == gi) begin
                    in_sel_reg[gi] <= wb_dat_i[SEL_W-1:0];
                end
            end
            logic [4:0] code;
            logic [3:0] low;
            logic valid_a;
            logic valid_c;
            assign code = in_sel_reg[gi];
            assign low = {1'b0, code[2:0]};
            assign valid_a = code[4:3] == IN_PORT_A_BASE[4:3] && int'(low) < PINS_PER_PORT;
            assign valid_c = code[4:3] == IN_PORT_C_BASE[4:3] && int'(low) < PINS_PER_PORT;
            // reserved codes give a low input; digital pins only
            assign periph_in[gi] = valid_a ? pin_in[int'(low)] :
                valid_c ? pin_in[PINS_PER_PORT + int'(low)] : 1'b0;
        end
        for (gi = 0; gi < N_PINS; gi++) begin : g_out
            always_ff @(posedge clk) begin
                if (!por_n) begin
                    out_sel_reg[gi] <= OUT_SEL_RESET;
                end else if (sel_wr_ok && hit_out && int'(word_idx) == gi) begin
                    out_sel_reg[gi] <= wb_dat_i[SEL_W-1:0];
                end
            end
            pin_output_mux u_mux (
                .sel(out_sel_reg[gi]),
                .latch_bit(port_output_latch_bit[gi]),
                .dir_input(pin_direction_control[gi]),
                .periph_out(periph_out),
                .periph_oe_n(periph_oe_n),
                .pin_out(pin_out[gi]),
                .pin_oe_n(pin_oe_n[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux: selectors always readable
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_lock) begin
            rdata_next[LOCK_BIT] = routing_locked;
        end else if (hit_in) begin
            rdata_next[SEL_W-1:0] = in_sel_reg[int'(word_idx) % N_INPUTS];
        end else if (hit_out) begin
            rdata_next[SEL_W-1:0] = out_sel_reg[int'(word_idx) % N_PINS];
        end
    end

    // one-cycle ack or error, data registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && mapped;
            err_reg <= req && !mapped;
            if (req && !wb_we_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LOCKED_NO_WRITE: assert property (@(posedge clk) disable iff (!por_n)
        (routing_locked && wr_go && hit_out && word_idx == 6'h00) |=> $stable(out_sel_reg[0]))
        else $error("selector changed while locked");
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!por_n)
        (!routing_locked && wr_go && hit_out && word_idx == 6'h00)
        |=> out_sel_reg[0] == $past(wb_dat_i[4:0]))
        else $error("selector write not stored");
    AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    AST_LATCH_DEFAULT: assert property (@(posedge clk) disable iff (!por_n)
        out_sel_reg[0] == SRC_LATCH |-> pin_out[0] == port_output_latch_bit[0] &&
        pin_oe_n[0] == pin_direction_control[0])
        else $error("latch source not routed");
    AST_READ_ZERO_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o |-> wb_dat_o[31:5] == 27'h0)
        else $error("unused read bits not zero");
    AST_INPUT_PORT_C: assert property (@(posedge clk) disable iff (!por_n)
        in_sel_reg[0] == 5'h10 |-> periph_in[0] == pin_in[PINS_PER_PORT])
        else $error("port c input not routed");
    AST_SLEEP_STABLE: assert property (@(posedge clk) disable iff (!por_n)
        (sleep_active && !wr_go) |=> $stable(out_sel_reg[0]) && $stable(in_sel_reg[0]))
        else $error("selection changed in sleep");
    AST_SOFT_RESET_KEEPS: assert property (@(posedge clk) disable iff (!por_n)
        (!rst_n && !wr_go) |=> $stable(out_sel_reg[0]))
        else $error("soft reset changed selection");
    COV_READ: cover property (@(posedge clk) wb_ack_o && !wb_we_i && hit_out);
    COV_ERR: cover property (@(posedge clk) wb_err_o);
    COV_PERIPH: cover property (@(posedge clk) out_sel_reg[0] == SRC_SER_CLK);
endmodule

// file: pin_far_side.sv
// far-side model: peripheral outputs, port latch and direction, external pin levels
`timescale 1ns/1ps
module pin_far_side
    import pin_routing_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] noise,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe_n,
    output logic [PO_COUNT-1:0] periph_out,
    output logic [PO_COUNT-1:0] periph_oe_n,
    output logic [11:0] latch_bit,
    output logic [11:0] dir_bit,
    output logic [11:0] pin_in
);
    logic [31:0] w0_reg = 32'h0;
    logic [31:0] w1_reg = 32'h0;
    logic [31:0] w2_reg = 32'h0;
    // peripherals and port bits take new values every cycle
    always @(posedge clk) begin
        w0_reg <= noise;
        w1_reg <= w0_reg ^ {noise[15:0], noise[31:16]};
        w2_reg <= ~w1_reg;
    end
    assign periph_out = w0_reg[19:0];
    assign periph_oe_n = w1_reg[19:0]; // drivers enable and release at will
    assign latch_bit = w0_reg[31:20];
    assign dir_bit = w1_reg[31:20];
    // a driven pin reads back its own level, a released one shows changing noise
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & w2_reg[11:0]);
endmodule

// file: peripheral_pin_routing_lock_bench.sv
// self-checking bench for the pin routing block with its far-side model
`timescale 1ns/1ps
module peripheral_pin_routing_lock_bench;
    import pin_routing_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic one_shot = 1'b0;
    logic sleep = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] wsel = 4'hF;
    logic [3:0] sel_mask = 4'hF;
    logic [31:0] rdat, q;
    logic ack, err, e, locked;
    logic exp_locked, was_set;
    logic [18:0] periph_in;
    logic [11:0] pin_out, pin_oe_n, pin_in, far_latch, far_dir;
    logic [PO_COUNT-1:0] far_out, far_oe;
    logic [31:0] rnd = 32'h6EA6892D;
    logic [4:0] in_sel [19];
    logic [4:0] out_sel [12];
    int fail_count = 0;
    int comparisons = 0;
    always #20 clk = ~clk;
    // ----------------------------------------
    // design, far side and random source
    // ----------------------------------------
    peripheral_pin_routing_lock #(.N_INPUTS(19), .N_PINS(12)) dut (.clk(clk), .rst_n(rst_n),
        .por_n(por_n), .one_shot_lock_config(one_shot), .sleep_active(sleep), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(wsel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_in(pin_in),
        .port_output_latch_bit(far_latch), .pin_direction_control(far_dir),
        .periph_out(far_out), .periph_oe_n(far_oe), .periph_in(periph_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .routing_locked(locked));
    pin_far_side far (.clk(clk), .noise(rnd), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .periph_out(far_out), .periph_oe_n(far_oe), .latch_bit(far_latch),
        .dir_bit(far_dir), .pin_in(pin_in));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    always @(posedge clk) rnd <= xs(rnd);
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic int src_idx(input logic [4:0] c);
        if (c >= 5'h02 && c <= 5'h05) return int'(c) - 2;
        if (c >= 5'h08 && c <= 5'h0D) return int'(c) - 4;
        if (c >= 5'h14 && c <= 5'h19) return int'(c) - 10;
        if (c >= 5'h1C) return int'(c) - 12;
        return -1;
    endfunction
    // returns {oe_n, level}
    function automatic logic [1:0] exp_pin(input logic [4:0] c, input int p);
        int k;
        k = src_idx(c);
        if (c == SRC_LATCH) return {far_dir[p], far_latch[p]};
        if (k < 0) return {far_dir[p], 1'b0};
        if ((k >= PO_WAVE && k <= PO_WAVE + 3) || k == PO_SYNC_DATA || k == PO_SER_CLK
            || k == PO_SER_DATA) return {far_oe[k], far_out[k]};
        return {far_dir[p], far_out[k]};
    endfunction
    function automatic logic exp_in(input logic [4:0] c);
        if (c < 5'h06) return pin_in[c];
        if (c >= 5'h10 && c <= 5'h15) return pin_in[int'(c) - 10];
        return 1'b0;
    endfunction
    function automatic logic [7:0] in_adr(input int i);
        return ADDR_IN_BASE + 8'(4 * i);
    endfunction
    function automatic logic [7:0] out_adr(input int p);
        return ADDR_OUT_BASE + 8'(4 * p);
    endfunction
    // ----------------------------------------
    // checking, bus cycles and closing
    // ----------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wsel <= sel_mask;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        if (ack !== 1'b1 && err !== 1'b1) begin
            fail_count++;
            $display("mismatch bus_answer expected ack seen none");
            print_verdict();
        end
        rq = rdat;
        re = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d}, q, e);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, q, e);
        check(what, q, exp);
    endtask
    task automatic set_in(input int i, input logic [4:0] c);
        wr(in_adr(i), {rnd[7:5], c});
        if (!exp_locked) in_sel[i] = c;
    endtask
    task automatic set_out(input int p, input logic [4:0] c);
        wr(out_adr(p), {rnd[7:5], c});
        if (!exp_locked) out_sel[p] = c;
    endtask
    task automatic rd_all();
        for (int p = 0; p < 12; p++) rd_chk("out_sel", out_adr(p), {27'h0, out_sel[p]});
        for (int i = 0; i < 19; i++) rd_chk("in_sel", in_adr(i), {27'h0, in_sel[i]});
    endtask
    task automatic chk_pins();
        logic [1:0] x;
        @(negedge clk);
        for (int p = 0; p < 12; p++) begin
            x = exp_pin(out_sel[p], p);
            check("pin_out", pin_out[p], x[0]);
            check("pin_oe_n", pin_oe_n[p], x[1]);
        end
        for (int i = 0; i < 19; i++) check("periph_in", periph_in[i], exp_in(in_sel[i]));
    endtask
    // software side of the key sequence, then the lock bit is read back
    task automatic lock_seq(input logic [7:0] v);
        wr(ADDR_LOCK, KEY_FIRST);
        wr(ADDR_LOCK, KEY_SECOND);
        wr(ADDR_LOCK, v);
        if (!(one_shot && was_set)) begin
            exp_locked = v[0];
            was_set = was_set | v[0];
        end
        rd_chk("lock", ADDR_LOCK, {31'h0, exp_locked});
        check("routing_locked", locked, exp_locked);
    endtask
    task automatic clear_track();
        exp_locked = 1'b0;
        was_set = 1'b0;
        for (int p = 0; p < 12; p++) out_sel[p] = OUT_SEL_RESET;
        for (int i = 0; i < 19; i++) in_sel[i] = IN_SEL_RESET;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clear_track();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rd_chk("lock", ADDR_LOCK, 32'h0);
        rd_all();
        for (int c = 0; c < 32; c++) begin
            set_out(c % 12, 5'(c));
            chk_pins();
        end
        repeat (4) begin
            for (int i = 0; i < 19; i++) set_in(i, rnd[5] ? rnd[4:0] : {rnd[4], 1'b0, 3'(rnd[2:0] % 6)});
            for (int p = 0; p < 12; p++) set_out(p, rnd[4:0]);
            rd_all();
            chk_pins();
        end
        set_in(14, 5'h11);
        set_out(7, SRC_SER_DATA);
        chk_pins();
        sel_mask = 4'hE;
        wr(out_adr(1), 8'h1F);
        sel_mask = 4'hF;
        rd_chk("masked_write", out_adr(1), {27'h0, out_sel[1]});
        bus(1'b0, 8'hFC, 32'h0, q, e);
        check("unmapped_err", e, 1'b1);
        lock_seq(8'h01);
        set_out(0, SRC_MOD);
        set_in(0, 5'h15);
        rd_all();
        chk_pins();
        wr(ADDR_LOCK, KEY_FIRST);
        wr(ADDR_LOCK, 8'h00);
        wr(ADDR_LOCK, KEY_SECOND);
        wr(ADDR_LOCK, 8'h00);
        rd_chk("lock", ADDR_LOCK, 32'h1);
        lock_seq(8'h00);
        lock_seq(8'hFF);
        lock_seq(8'h00);
        lock_seq(8'h01);
        sleep <= 1'b1;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        sleep <= 1'b0;
        rst_n <= 1'b1;
        rd_all();
        rd_chk("lock", ADDR_LOCK, {31'h0, exp_locked});
        por_n <= 1'b0;
        one_shot <= 1'b1;
        @(posedge clk);
        por_n <= 1'b1;
        clear_track();
        rd_chk("lock", ADDR_LOCK, 32'h0);
        rd_all();
        set_out(3, SRC_CAPTURE_COMPARE_ONE);
        lock_seq(8'h01);
        lock_seq(8'h00);
        set_out(3, SRC_CAPTURE_COMPARE_TWO);
        rd_all();
        chk_pins();
        print_verdict();
    end
endmodule
